/* mbrsu_pkg.sv */
// Constants for the serial request handler of the heater controller.
// Assumes one 40 MHz core clock; the serial line pins are synchronous inputs.
package mbrsu_pkg;

    localparam int          CLK_HZ       = 40_000_000;
    localparam int          BAUD_1200    = 1200;
    localparam int          BAUD_2400    = 2400;
    localparam int          BAUD_4800    = 4800;
    localparam int          BAUD_9600    = 9600;
    localparam int          DIV_W        = 16;
    localparam logic [5:0]  SILENCE_BITS = 6'h23;     // 3.5 chars of 10 bits
    localparam logic [3:0]  CHAR_LAST    = 4'h9;      // 10 bit times per char
    localparam logic [2:0]  DATA_LAST    = 3'h7;

    localparam logic [7:0]  FC_READ      = 8'h03;
    localparam logic [7:0]  FC_CLEAR     = 8'h05;
    localparam logic [7:0]  FC_WRITE1    = 8'h06;
    localparam logic [7:0]  FC_WRITEN    = 8'h10;
    localparam logic [7:0]  EXC_FLAG     = 8'h80;
    localparam logic [7:0]  EXC_FUNC     = 8'h01;
    localparam logic [7:0]  EXC_ADDR     = 8'h02;
    localparam logic [7:0]  EXC_VALUE    = 8'h03;

    localparam logic [7:0]  MODNUM_MIN   = 8'h01;
    localparam logic [7:0]  MODNUM_MAX   = 8'hFA;

    localparam logic [16:0] READ_LAST    = 17'h000A4;
    localparam logic [15:0] READ_MAX_CNT = 16'h007D;  // byte count fits one byte
    localparam logic [15:0] CLR_FIRST    = 16'h00A5;
    localparam logic [15:0] CLR_LAST     = 16'h00BA;
    localparam logic [16:0] SETUP_FIRST  = 17'h00000;
    localparam logic [16:0] SETTING_FIRST = 17'h0001F;
    localparam logic [16:0] SETTING_LAST = 17'h0002B; // setup 0..30 adjoins
    localparam logic [16:0] HSET_FIRST   = 17'h00047;
    localparam logic [16:0] HSET_LAST    = 17'h0006C;
    localparam logic [15:0] CLR_VALUE    = 16'hFF00;
    localparam logic [15:0] NOP_VALUE    = 16'h0000;

    localparam logic [15:0] CRC_INIT     = 16'hFFFF;
    localparam logic [15:0] CRC_POLY     = 16'hA001;
    localparam logic [15:0] FIXED_LEN    = 16'h0008;
    localparam logic [15:0] WRN_HDR_LEN  = 16'h0009;
    localparam logic [7:0]  ERR_LEN      = 8'h05;
    localparam logic [7:0]  ECHO_LEN     = 8'h08;
    localparam logic [7:0]  READ_OVH     = 8'h05;
    localparam logic [7:0]  WRN_DATA_POS = 8'h07;
    localparam logic [7:0]  WR1_DATA_POS = 8'h04;
    localparam logic [7:0]  MIN_FRAME    = 8'h04;

endpackage

/* mbrsu_slave.sv */
// Serial request handler: receives, checks and answers master packets.
// Assumes an external register store with a one-cycle read latency and a
// half-duplex line driver enabled by tx_drive_en.
`timescale 1ns/1ps

module mbrsu_slave #(
    parameter int BAUD_DIV_1200 = mbrsu_pkg::CLK_HZ / mbrsu_pkg::BAUD_1200,
    parameter int BAUD_DIV_2400 = mbrsu_pkg::CLK_HZ / mbrsu_pkg::BAUD_2400,
    parameter int BAUD_DIV_4800 = mbrsu_pkg::CLK_HZ / mbrsu_pkg::BAUD_4800,
    parameter int BAUD_DIV_9600 = mbrsu_pkg::CLK_HZ / mbrsu_pkg::BAUD_9600,
    parameter int RX_MAX        = 32
) (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst,
    // Configuration
    input  wire logic [1:0]  baud_sel,
    input  wire logic [7:0]  module_no,
    // Serial line
    input  wire logic        rx_line,
    output logic             tx_line,
    output logic             tx_drive_en,
    // Register read port
    output logic [15:0]      reg_rd_idx,
    input  wire logic [15:0] reg_rd_data,
    // Register write port
    output logic             reg_wr_strobe,
    output logic [15:0]      reg_wr_idx,
    output logic [15:0]      reg_wr_data,
    // Alarm and statistic clear port
    output logic             clr_strobe,
    output logic [15:0]      clr_idx
);

    localparam int IW = $clog2(RX_MAX);

    typedef enum logic [1:0] {
        RX_IDLE  = 2'b00,
        RX_START = 2'b01,
        RX_DATA  = 2'b10,
        RX_STOP  = 2'b11
    } mbrsu_rx_e;

    typedef enum logic [2:0] {
        S_RECV     = 3'b000,
        S_CHECK    = 3'b001,
        S_WRITE    = 3'b010,
        S_TX_LOAD  = 3'b011,
        S_TX_SHIFT = 3'b100
    } mbrsu_state_e;

    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        r = c ^ {8'h00, d};
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r >> 1) ^ mbrsu_pkg::CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction

    mbrsu_rx_e         rx_state;
    mbrsu_state_e      state;
    ////////////////////////////////////////////////////////////////////////////
    logic [mbrsu_pkg::DIV_W-1:0] bit_div;
    logic [mbrsu_pkg::DIV_W-1:0] rx_tmr;
    logic [mbrsu_pkg::DIV_W-1:0] sil_tmr;
    logic [mbrsu_pkg::DIV_W-1:0] tx_tmr;
    logic [2:0]        rx_bit;
    logic [7:0]        rx_sh;
    logic              byte_done;
    logic [5:0]        sil_bits;
    logic [7:0]        rx_buf [RX_MAX];
    logic [IW:0]       rx_len;
    logic              rx_bad;
    logic [15:0]       rx_crc;
    logic              frame_end;
    logic              frame_ok;
    logic [15:0]       f_idx;
    logic [15:0]       f_val;
    logic [16:0]       f_end;
    logic [15:0]       len16;
    logic [7:0]        next_exc;
    logic [7:0]        next_len;
    logic [7:0]        exc_q;
    logic [7:0]        len_q;
    logic [7:0]        pos;
    logic [7:0]        wr_k;
    logic [7:0]        wr_last;
    logic [7:0]        wr_base;
    logic [IW-1:0]     wr_pos;
    logic [7:0]        next_tx_byte;
    logic [15:0]       tx_crc;
    logic [9:0]        tx_sh;
    logic [3:0]        tx_bits;

    // Bit period scales with the chosen rate, and so does the silence
    always_comb begin
        case (baud_sel)
            2'b00:   bit_div = mbrsu_pkg::DIV_W'(BAUD_DIV_1200);
            2'b01:   bit_div = mbrsu_pkg::DIV_W'(BAUD_DIV_2400);
            2'b10:   bit_div = mbrsu_pkg::DIV_W'(BAUD_DIV_4800);
            default: bit_div = mbrsu_pkg::DIV_W'(BAUD_DIV_9600);
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Character receiver, sampled mid-bit
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rx_state  <= RX_IDLE;
            rx_tmr    <= '0;
            rx_bit    <= '0;
            rx_sh     <= 8'h00;
            byte_done <= 1'b0;
        end else begin
            byte_done <= 1'b0;
            rx_tmr    <= rx_tmr + 1'b1;
            case (rx_state)
                RX_IDLE: begin
                    rx_tmr <= '0;
                    if (!rx_line && state == S_RECV) begin
                        rx_state <= RX_START;
                    end
                end
                RX_START: begin
                    if (rx_tmr == (bit_div >> 1)) begin
                        rx_tmr   <= '0;
                        rx_bit   <= '0;
                        rx_state <= rx_line ? RX_IDLE : RX_DATA;
                    end
                end
                RX_DATA: begin
                    if (rx_tmr == bit_div - 1'b1) begin
                        rx_tmr <= '0;
                        rx_sh  <= {rx_line, rx_sh[7:1]};
                        rx_bit <= rx_bit + 1'b1;
                        if (rx_bit == mbrsu_pkg::DATA_LAST) begin
                            rx_state <= RX_STOP;
                        end
                    end
                end
                RX_STOP: begin
                    if (rx_tmr == bit_div - 1'b1) begin
                        byte_done <= rx_line;
                        rx_state  <= RX_IDLE;
                    end
                end
                default: rx_state <= RX_IDLE;
            endcase
        end
    end

    // Line silence in whole bit times since the last character
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sil_tmr  <= '0;
            sil_bits <= mbrsu_pkg::SILENCE_BITS;
        end else if (rx_state != RX_IDLE || !rx_line) begin
            sil_tmr  <= '0;
            sil_bits <= '0;
        end else if (sil_bits != mbrsu_pkg::SILENCE_BITS) begin
            sil_tmr <= sil_tmr + 1'b1;
            if (sil_tmr == bit_div - 1'b1) begin
                sil_tmr  <= '0;
                sil_bits <= sil_bits + 1'b1;
            end
        end
    end

    assign frame_end = state == S_RECV && rx_len != '0
                       && sil_bits == mbrsu_pkg::SILENCE_BITS;

    // Packet buffer with running CRC; residue zero means a clean packet
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rx_len <= '0;
            rx_bad <= 1'b0;
            rx_crc <= mbrsu_pkg::CRC_INIT;
            for (int i = 0; i < RX_MAX; i++) begin
                rx_buf[i] <= 8'h00;
            end
        end else if (state == S_CHECK) begin
            rx_len <= '0;
            rx_bad <= 1'b0;
            rx_crc <= mbrsu_pkg::CRC_INIT;
        end else if (byte_done && state == S_RECV) begin
            rx_crc <= crc_step(rx_crc, rx_sh);
            if (rx_len == (IW + 1)'(RX_MAX)) begin
                rx_bad <= 1'b1;
            end else begin
                rx_buf[rx_len[IW-1:0]] <= rx_sh;
                rx_len <= rx_len + 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Request decoding
    assign f_idx = {rx_buf[2], rx_buf[3]};
    assign f_val = {rx_buf[4], rx_buf[5]};
    assign f_end = {1'b0, f_idx} + {1'b0, f_val} - 17'h00001;
    assign len16 = 16'(rx_len);

    assign frame_ok = !rx_bad && rx_len >= (IW + 1)'(mbrsu_pkg::MIN_FRAME)
                      && rx_crc == 16'h0000
                      && module_no >= mbrsu_pkg::MODNUM_MIN
                      && module_no <= mbrsu_pkg::MODNUM_MAX
                      && rx_buf[0] == module_no;

    always_comb begin
        next_exc = 8'h00;
        case (rx_buf[1])
            mbrsu_pkg::FC_READ: begin
                if (len16 != mbrsu_pkg::FIXED_LEN || f_val == 16'h0000
                    || f_val > mbrsu_pkg::READ_MAX_CNT) begin
                    next_exc = mbrsu_pkg::EXC_VALUE;
                end else if (f_end > mbrsu_pkg::READ_LAST) begin
                    next_exc = mbrsu_pkg::EXC_ADDR;
                end
            end
            mbrsu_pkg::FC_CLEAR: begin
                if (len16 != mbrsu_pkg::FIXED_LEN) begin
                    next_exc = mbrsu_pkg::EXC_VALUE;
                end else if (f_idx < mbrsu_pkg::CLR_FIRST || f_idx > mbrsu_pkg::CLR_LAST) begin
                    next_exc = mbrsu_pkg::EXC_ADDR;
                end else if (f_val != mbrsu_pkg::CLR_VALUE && f_val != mbrsu_pkg::NOP_VALUE) begin
                    next_exc = mbrsu_pkg::EXC_VALUE;
                end
            end
            mbrsu_pkg::FC_WRITE1: begin
                if (len16 != mbrsu_pkg::FIXED_LEN) begin
                    next_exc = mbrsu_pkg::EXC_VALUE;
                end else if (!({1'b0, f_idx} <= mbrsu_pkg::SETTING_LAST
                               || ({1'b0, f_idx} >= mbrsu_pkg::HSET_FIRST
                                   && {1'b0, f_idx} <= mbrsu_pkg::HSET_LAST))) begin
                    next_exc = mbrsu_pkg::EXC_ADDR;
                end
            end
            mbrsu_pkg::FC_WRITEN: begin
                if (f_val == 16'h0000 || {8'h00, rx_buf[6]} != {f_val[14:0], 1'b0}
                    || len16 != mbrsu_pkg::WRN_HDR_LEN + {f_val[14:0], 1'b0}) begin
                    next_exc = mbrsu_pkg::EXC_VALUE;
                end else if (!(({1'b0, f_idx} >= mbrsu_pkg::SETTING_FIRST
                                && f_end <= mbrsu_pkg::SETTING_LAST)
                               || ({1'b0, f_idx} >= mbrsu_pkg::HSET_FIRST
                                   && f_end <= mbrsu_pkg::HSET_LAST))) begin
                    next_exc = mbrsu_pkg::EXC_ADDR;
                end
            end
            default: next_exc = mbrsu_pkg::EXC_FUNC;
        endcase
    end

    assign next_len = (next_exc != 8'h00) ? mbrsu_pkg::ERR_LEN
                    : (rx_buf[1] == mbrsu_pkg::FC_READ)
                      ? mbrsu_pkg::READ_OVH + {f_val[6:0], 1'b0}
                      : mbrsu_pkg::ECHO_LEN;

    ////////////////////////////////////////////////////////////////////////////
    // Answer byte for the current position
    always_comb begin
        if (pos == 8'h00) begin
            next_tx_byte = rx_buf[0];
        end else if (pos == 8'h01) begin
            next_tx_byte = (exc_q != 8'h00) ? (rx_buf[1] | mbrsu_pkg::EXC_FLAG)
                                            : rx_buf[1];
        end else if (pos == len_q - 8'h02) begin
            next_tx_byte = tx_crc[7:0];
        end else if (pos == len_q - 8'h01) begin
            next_tx_byte = tx_crc[15:8];
        end else if (exc_q != 8'h00) begin
            next_tx_byte = exc_q;
        end else if (rx_buf[1] == mbrsu_pkg::FC_READ) begin
            if (pos == 8'h02) begin
                next_tx_byte = {f_val[6:0], 1'b0};
            end else begin
                next_tx_byte = pos[0] ? reg_rd_data[15:8] : reg_rd_data[7:0];
            end
        end else begin
            next_tx_byte = rx_buf[pos[IW-1:0]];
        end
    end

    assign wr_last = (rx_buf[1] == mbrsu_pkg::FC_WRITEN) ? f_val[7:0] - 8'h01 : 8'h00;
    assign wr_base = (rx_buf[1] == mbrsu_pkg::FC_WRITEN) ? mbrsu_pkg::WRN_DATA_POS
                                                         : mbrsu_pkg::WR1_DATA_POS;
    assign wr_pos  = IW'(wr_base + {wr_k[6:0], 1'b0});

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer: check, write, then transmit the answer
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state      <= S_RECV;
            exc_q      <= 8'h00;
            len_q      <= 8'h00;
            pos        <= 8'h00;
            wr_k       <= 8'h00;
            tx_crc     <= mbrsu_pkg::CRC_INIT;
            tx_sh      <= 10'h3FF;
            tx_tmr     <= '0;
            tx_bits    <= 4'h0;
            reg_rd_idx <= 16'h0000;
        end else begin
            case (state)
                S_RECV: begin
                    if (frame_end) begin
                        state <= S_CHECK;
                    end
                end
                S_CHECK: begin
                    exc_q      <= next_exc;
                    len_q      <= next_len;
                    pos        <= 8'h00;
                    wr_k       <= 8'h00;
                    tx_crc     <= mbrsu_pkg::CRC_INIT;
                    reg_rd_idx <= f_idx;
                    if (!frame_ok) begin
                        state <= S_RECV;
                    end else if (next_exc == 8'h00 && (rx_buf[1] == mbrsu_pkg::FC_WRITE1
                                 || rx_buf[1] == mbrsu_pkg::FC_WRITEN)) begin
                        state <= S_WRITE;
                    end else begin
                        state <= S_TX_LOAD;
                    end
                end
                S_WRITE: begin
                    wr_k <= wr_k + 8'h01;
                    if (wr_k == wr_last) begin
                        state <= S_TX_LOAD;
                    end
                end
                S_TX_LOAD: begin
                    tx_sh   <= {1'b1, next_tx_byte, 1'b0};
                    tx_tmr  <= '0;
                    tx_bits <= 4'h0;
                    if (pos < len_q - 8'h02) begin
                        tx_crc <= crc_step(tx_crc, next_tx_byte);
                    end
                    if (exc_q == 8'h00 && rx_buf[1] == mbrsu_pkg::FC_READ
                        && pos > 8'h03 && !pos[0]) begin
                        reg_rd_idx <= reg_rd_idx + 16'h0001;
                    end
                    state <= S_TX_SHIFT;
                end
                S_TX_SHIFT: begin
                    tx_tmr <= tx_tmr + 1'b1;
                    if (tx_tmr == bit_div - 1'b1) begin
                        tx_tmr  <= '0;
                        tx_sh   <= {1'b1, tx_sh[9:1]};
                        tx_bits <= tx_bits + 4'h1;
                        if (tx_bits == mbrsu_pkg::CHAR_LAST) begin
                            pos   <= pos + 8'h01;
                            state <= (pos == len_q - 8'h01) ? S_RECV : S_TX_LOAD;
                        end
                    end
                end
                default: state <= S_RECV;
            endcase
        end
    end

    assign tx_line = tx_sh[0];

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            tx_drive_en <= 1'b0;
        end else begin
            tx_drive_en <= state == S_TX_LOAD || state == S_TX_SHIFT;
        end
    end

    // Register writes only after the whole packet has proven clean
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            reg_wr_strobe <= 1'b0;
            reg_wr_idx    <= 16'h0000;
            reg_wr_data   <= 16'h0000;
        end else begin
            reg_wr_strobe <= state == S_WRITE;
            if (state == S_WRITE) begin
                reg_wr_idx  <= f_idx + {8'h00, wr_k};
                reg_wr_data <= {rx_buf[wr_pos], rx_buf[wr_pos + IW'(1)]};
            end
        end
    end

    // Zero value is accepted but raises no clear
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            clr_strobe <= 1'b0;
            clr_idx    <= 16'h0000;
        end else begin
            clr_strobe <= state == S_CHECK && frame_ok && next_exc == 8'h00
                          && rx_buf[1] == mbrsu_pkg::FC_CLEAR
                          && f_val == mbrsu_pkg::CLR_VALUE;
            if (state == S_CHECK) begin
                clr_idx <= f_idx;
            end
        end
    end

endmodule // mbrsu_slave

/* mbrsu_slave_props.sv */
// Port-level checker for the serial request handler.
// Bound to mbrsu_slave; sees its top-level ports only.
`timescale 1ns/1ps

module mbrsu_slave_props #(
    parameter int BAUD_DIV_1200 = 33333,
    parameter int BAUD_DIV_2400 = 16666,
    parameter int BAUD_DIV_4800 = 8333,
    parameter int BAUD_DIV_9600 = 4166
) (
    // Clock, reset and configuration
    input wire logic        core_clk,
    input wire logic        rst,
    input wire logic [1:0]  baud_sel,
    input wire logic [7:0]  module_no,
    // Serial line and action ports
    input wire logic        rx_line,
    input wire logic        tx_line,
    input wire logic        tx_drive_en,
    input wire logic        reg_wr_strobe,
    input wire logic [15:0] reg_wr_idx,
    input wire logic        clr_strobe,
    input wire logic [15:0] clr_idx
);
    logic [31:0] div;
    logic [31:0] idle_run;

    assign div = (baud_sel == 2'h0) ? BAUD_DIV_1200 : (baud_sel == 2'h1) ? BAUD_DIV_2400
               : (baud_sel == 2'h2) ? BAUD_DIV_4800 : BAUD_DIV_9600;

    // Saturates so that long pauses never wrap back to a short count
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            idle_run <= 32'hFFFFFFFF;
        end else if (!rx_line) begin
            idle_run <= 32'h00000000;
        end else if (idle_run != 32'hFFFFFFFF) begin
            idle_run <= idle_run + 32'h00000001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence drive_up_s;
        $rose(tx_drive_en);
    endsequence
    sequence start_bit_s;
        !tx_line;
    endsequence

    tx_idle_a: assert property (!tx_drive_en |-> tx_line)
        else $error("Transmit line low while not driving");
    answer_gap_a: assert property (drive_up_s |-> idle_run >= 35 * div)
        else $error("Answer started before end-of-packet silence");
    own_addr_a: assert property (drive_up_s |-> module_no >= mbrsu_pkg::MODNUM_MIN
        && module_no <= mbrsu_pkg::MODNUM_MAX) else $error("Answer with invalid module number");
    start_soon_a: assert property (drive_up_s |-> ##[0:40] start_bit_s)
        else $error("No start bit after driver enable");
    clr_pulse_a: assert property (clr_strobe |=> !clr_strobe)
        else $error("Clear strobe longer than one cycle");
    clr_range_a: assert property (clr_strobe |-> clr_idx >= mbrsu_pkg::CLR_FIRST
        && clr_idx <= mbrsu_pkg::CLR_LAST) else $error("Clear index outside reset range");
    wr_range_a: assert property (reg_wr_strobe |-> reg_wr_idx <= 16'h002B
        || (reg_wr_idx >= 16'h0047 && reg_wr_idx <= 16'h006C)) else $error("Write index illegal");
    wr_step_a: assert property (reg_wr_strobe && $past(reg_wr_strobe)
        |-> reg_wr_idx == $past(reg_wr_idx) + 16'h0001) else $error("Group write index skipped");
    act_quiet_a: assert property ((clr_strobe || reg_wr_strobe) |-> idle_run >= 35 * div)
        else $error("Action taken before packet ended");

endmodule // mbrsu_slave_props

bind mbrsu_slave mbrsu_slave_props #(
    .BAUD_DIV_1200(BAUD_DIV_1200), .BAUD_DIV_2400(BAUD_DIV_2400),
    .BAUD_DIV_4800(BAUD_DIV_4800), .BAUD_DIV_9600(BAUD_DIV_9600)
) u_props (
    .core_clk(core_clk), .rst(rst), .baud_sel(baud_sel), .module_no(module_no),
    .rx_line(rx_line), .tx_line(tx_line), .tx_drive_en(tx_drive_en),
    .reg_wr_strobe(reg_wr_strobe), .reg_wr_idx(reg_wr_idx),
    .clr_strobe(clr_strobe), .clr_idx(clr_idx)
);

/* mbrsu_master.sv */
// Behavioural bus master: sends framed requests, collects answers.
// Assumes div core clocks per bit, kept equal to the handler's selected divider.
`timescale 1ns/1ps

module mbrsu_master #(
    parameter int DIV = 16
) (
    // Clock and serial line
    input  wire logic core_clk,
    output logic      line_out,
    input  wire logic tx_line,
    input  wire logic tx_drive_en
);
    int div = DIV;

    initial line_out = 1'b1;

    function automatic logic [15:0] crc(input logic [7:0] q[$]);
        logic [15:0] c;
        c = 16'hFFFF;
        foreach (q[i]) begin
            c = c ^ {8'h00, q[i]};
            for (int b = 0; b < 8; b++) begin
                c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
            end
        end
        return c;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    task automatic send(input logic [7:0] q[$], input bit bad);
        logic [15:0] c;
        c = crc(q) ^ {15'h0000, bad};
        q.push_back(c[7:0]);
        q.push_back(c[15:8]);
        foreach (q[i]) begin
            for (int b = 0; b < 10; b++) begin
                @(posedge core_clk);
                #1 line_out = (b == 0) ? 1'b0 : (b == 9) ? 1'b1 : q[i][b - 1];
                repeat (div - 1) @(posedge core_clk);
            end
        end
    endtask

    // Ends once the driver drops, or after a long quiet spell
    task automatic get(output logic [7:0] q[$]);
        logic [7:0] v;
        int n;
        n = 0;
        q = {};
        while (n < 3000) begin
            @(posedge core_clk);
            n++;
            if (tx_drive_en && !tx_line) begin
                repeat (div / 2) @(posedge core_clk);
                for (int b = 0; b < 8; b++) begin
                    repeat (div) @(posedge core_clk);
                    v[b] = tx_line;
                end
                repeat (div) @(posedge core_clk);
                q.push_back(v);
                n = 0;
            end else if (!tx_drive_en && q.size() > 0) begin
                break;
            end
        end
    endtask

endmodule // mbrsu_master

/* mbrsu_slave_bench.sv */
// Self-checking bench for the serial request handler.
// Uses mbrsu_master as bus master; bit dividers shortened to multiples of 16.
`timescale 1ns/1ps

module mbrsu_slave_bench;
    localparam int DIV = 16;
    logic        core_clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  module_no = 8'h0B;
    logic [1:0]  baud_sel = 2'h3;
    logic        rx_line, tx_line, tx_drive_en, reg_wr_strobe, clr_strobe;
    logic [15:0] reg_rd_idx, reg_wr_idx, reg_wr_data, clr_idx;
    logic [15:0] reg_rd_data = 16'h0000;
    logic [31:0] last_wr, last_clr;
    int          err_count = 0, checked = 0, cyc = 0, n_wr = 0, n_clr = 0;

    always #12.5 core_clk = ~core_clk;

    always @(posedge core_clk) begin
        reg_rd_data <= {8'h5A, reg_rd_idx[7:0]};
        cyc++;
        if (reg_wr_strobe) begin n_wr++; last_wr = {reg_wr_idx, reg_wr_data}; end
        if (clr_strobe) begin n_clr++; last_clr = {16'h0000, clr_idx}; end
        if (cyc == 90000) begin err_count++; finish_test(); end
    end

    mbrsu_slave #(.BAUD_DIV_1200(DIV * 4), .BAUD_DIV_2400(DIV * 3), .BAUD_DIV_4800(DIV * 2),
                  .BAUD_DIV_9600(DIV), .RX_MAX(32)) DUT (
        .core_clk(core_clk), .rst(rst), .baud_sel(baud_sel), .module_no(module_no),
        .rx_line(rx_line), .tx_line(tx_line), .tx_drive_en(tx_drive_en),
        .reg_rd_idx(reg_rd_idx), .reg_rd_data(reg_rd_data), .reg_wr_strobe(reg_wr_strobe),
        .reg_wr_idx(reg_wr_idx), .reg_wr_data(reg_wr_data), .clr_strobe(clr_strobe),
        .clr_idx(clr_idx));
    mbrsu_master #(.DIV(DIV)) MASTER (.core_clk(core_clk), .line_out(rx_line),
        .tx_line(tx_line), .tx_drive_en(tx_drive_en));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    // Packed request and expected answer, first byte leftmost, CRC added here
    task automatic txn(input logic [87:0] r, input int nr, input logic [87:0] e,
                       input int ne, input bit bad);
        logic [7:0]  rq[$], ex[$], got[$];
        logic [15:0] c;
        for (int i = 0; i < nr; i++) rq.push_back(r[8 * (nr - 1 - i) +: 8]);
        for (int i = 0; i < ne; i++) ex.push_back(e[8 * (ne - 1 - i) +: 8]);
        c = MASTER.crc(ex);
        if (ne > 0) begin ex.push_back(c[7:0]); ex.push_back(c[15:8]); end
        MASTER.send(rq, bad);
        MASTER.get(got);
        chk(got.size(), ex.size());
        foreach (ex[i]) if (i < got.size()) chk(got[i], ex[i]);
    endtask

    task automatic read_cases;
        txn(48'h0B0300A30002, 6, 56'h0B03045AA35AA4, 7, 0);
        txn(48'h0B0300A40002, 6, 24'h0B8302, 3, 0);
    endtask

    // Slower rate: bit time and end-of-packet silence both follow the selection
    task automatic rate_case;
        @(posedge core_clk);
        #1 baud_sel = 2'h2;
        MASTER.div = 2 * DIV;
        txn(48'h0B0300000001, 6, 40'h0B03025A00, 5, 0);
        @(posedge core_clk);
        #1 baud_sel = 2'h3;
        MASTER.div = DIV;
    endtask

    task automatic clear_cases;
        int n;
        n = n_clr;
        txn(48'h0B0500BAFF00, 6, 48'h0B0500BAFF00, 6, 0);
        chk(last_clr, 32'h000000BA);
        txn(48'h0B0500A50000, 6, 48'h0B0500A50000, 6, 0);
        chk(n_clr - n, 1);
        txn(48'h0B0500A51234, 6, 24'h0B8503, 3, 0);
        txn(48'h0B0500BBFF00, 6, 24'h0B8502, 3, 0);
    endtask

    task automatic write_cases;
        int n;
        n = n_wr;
        txn(48'h0B06002C0001, 6, 24'h0B8602, 3, 0);
        txn(48'h0B06006C012C, 6, 48'h0B06006C012C, 6, 0);
        chk(last_wr, 32'h006C012C);
        txn(88'h0B1000470002040032_0BB8, 11, 48'h0B1000470002, 6, 0);
        chk(n_wr - n, 3);
        chk(last_wr, 32'h00480BB8);
        txn(48'h0B0700000001, 6, 24'h0B8701, 3, 0);
    endtask

    task automatic silent_cases;
        int n;
        n = n_clr;
        txn(48'h0B0500A6FF00, 6, 8'h00, 0, 1);
        chk(n_clr - n, 0);
        txn(48'h0C0300000001, 6, 8'h00, 0, 0);
        @(posedge core_clk);
        #1 module_no = 8'hFF;
        txn(48'hFF0300000001, 6, 8'h00, 0, 0);
        @(posedge core_clk);
        #1 module_no = 8'h0B;
    endtask

    task automatic finish_test;
        if (err_count == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        repeat (3) @(posedge core_clk);
        #1 rst = 1'b0;
        read_cases();
        rate_case();
        clear_cases();
        write_cases();
        silent_cases();
        finish_test();
    end

endmodule // mbrsu_slave_bench
